//--- core/jcr_pkg.sv
package jcr_pkg;

  localparam int ADDR_W = 5;
  localparam int NUM_REGS = 32;

  localparam logic [4:0] REG_HOLDOVER_MODE = 5'h0C;
  localparam logic [4:0] REG_DAC_TRIP = 5'h0E;
  localparam logic [4:0] REG_MANUAL_DAC = 5'h0F;
  localparam logic [4:0] REG_PATH_DELAY = 5'h18;
  localparam logic [4:0] REG_DAC_CLK = 5'h19;
  localparam logic [4:0] REG_LOOP2_LOCK = 5'h1A;
  localparam logic [4:0] REG_LOOP1_REF = 5'h1B;
  localparam logic [4:0] REG_LOOP2_REF = 5'h1C;
  localparam logic [4:0] REG_CAL_DIV = 5'h1D;
  localparam logic [4:0] REG_LOOP2_FB = 5'h1E;
  localparam logic [4:0] REG_READBACK = 5'h1F;

  // Field positions (low bit of each field)
  localparam int POS_HIGH_TRIP = 14;
  localparam int POS_LOW_TRIP = 6;
  localparam int POS_RAIL_DET = 5;
  localparam int POS_MANUAL_TUNING_VALUE = 22;
  localparam int POS_MAN_EN = 20;
  localparam int POS_COUNT = 6;
  localparam int POS_FORCE_HOLD = 5;
  localparam int POS_TRACK_EN = 8;
  localparam int POS_HOLD_MODE = 6;
  localparam int POS_WND1 = 6;
  localparam int POS_DAC_DIV = 22;
  localparam int POS_WND2 = 30;
  localparam int POS_DOUBLER = 29;
  localparam int POS_PRE_B = 22;
  localparam int POS_PRE_A = 20;
  localparam int POS_DIV14 = 6;
  localparam int POS_L2_REF = 20;
  localparam int POS_FAST_PDF = 23;
  localparam int POS_DIV18 = 5;
  localparam int POS_PRESCALER = 24;
  localparam int POS_RB_LEVEL = 21;
  localparam int POS_RB_ADDR = 16;
  localparam int POS_WLOCK = 5;
  localparam int POS_GRP_PD = 31;
  localparam int POS_GRP_SRC = 30;
  localparam int POS_SOFT_RST = 17;
  localparam int POS_POWERDOWN = 17;

  localparam logic [1:0] HOLD_MODE_ENABLE = 2'h2;
  localparam logic [9:0] DAC_FULL_SCALE = 10'h3FF;

  // Values after reset, already placed at their bit positions
  localparam logic [31:0] RST_HOLD_MODE = 32'h1B00_0180;
  localparam logic [31:0] RST_MANUAL_DAC = 32'h8000_8000;
  localparam logic [31:0] RST_PATH_DELAY = 32'h0000_00C0;
  localparam logic [31:0] RST_DAC_CLK = 32'h0101_0000;
  localparam logic [31:0] RST_LOOP2_LOCK = 32'h0008_0000;
  localparam logic [31:0] RST_LOOP1_REF = 32'h1000_1800;
  localparam logic [31:0] RST_LOOP2_REF = 32'h0040_3000;
  localparam logic [31:0] RST_CAL_DIV = 32'h0780_0600;
  localparam logic [31:0] RST_LOOP2_FB = 32'h0200_0600;
  localparam logic [31:0] RST_READBACK = 32'h001F_0000;

  function automatic logic [31:0] reset_value(input logic [4:0] idx);
    if (idx == REG_HOLDOVER_MODE) reset_value = RST_HOLD_MODE;
    else if (idx == REG_MANUAL_DAC) reset_value = RST_MANUAL_DAC;
    else if (idx == REG_PATH_DELAY) reset_value = RST_PATH_DELAY;
    else if (idx == REG_DAC_CLK) reset_value = RST_DAC_CLK;
    else if (idx == REG_LOOP2_LOCK) reset_value = RST_LOOP2_LOCK;
    else if (idx == REG_LOOP1_REF) reset_value = RST_LOOP1_REF;
    else if (idx == REG_LOOP2_REF) reset_value = RST_LOOP2_REF;
    else if (idx == REG_CAL_DIV) reset_value = RST_CAL_DIV;
    else if (idx == REG_LOOP2_FB) reset_value = RST_LOOP2_FB;
    else if (idx == REG_READBACK) reset_value = RST_READBACK;
    else reset_value = 32'h0000_0000;
  endfunction : reset_value

endpackage : jcr_pkg

//--- core/jcr_lock_counter.sv
`timescale 1ns/1ps
`default_nettype none
module jcr_lock_counter
  import jcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic in_window_i,
  input wire logic [13:0] target_i,
  output logic locked_o
);

  logic [13:0] count_q;

  // Counts in-window compare cycles; any miss starts the run over
  always_ff @(posedge clock_i) begin
    if (srst_i || !enable_i) begin
      count_q <= 14'h0000;
      locked_o <= 1'b0;
    end else if (tick_i) begin
      if (!in_window_i) begin
        count_q <= 14'h0000;
        locked_o <= 1'b0;
      end else if (count_q < target_i) begin
        count_q <= count_q + 14'h0001;
        locked_o <= (count_q + 14'h0001) >= target_i;
      end else begin
        locked_o <= 1'b1;
      end
    end
  end

endmodule : jcr_lock_counter
`default_nettype wire

//--- core/jcr_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
module jcr_config_regs
  import jcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_i,
  input wire logic serial_latch_enable_i,
  input wire logic pd1_tick_i,
  input wire logic pd2_tick_i,
  input wire logic loop1_in_window_i,
  input wire logic loop2_in_window_i,
  input wire logic [9:0] track_dac_i,
  output logic readback_data_o,
  output logic loop1_lock_o,
  output logic loop2_lock_o,
  output logic holdover_o,
  output logic [9:0] dac_value_o,
  output logic dac_update_o,
  output logic [13:0] loop1_ref_divider_o,
  output logic [13:0] loop1_fb_divider_o,
  output logic [11:0] loop2_ref_divider_o,
  output logic [17:0] loop2_fb_divider_o,
  output logic [2:0] loop2_prescaler_o,
  output logic [3:0] ref_input_a_prescale_o,
  output logic [3:0] ref_input_b_prescale_o,
  output logic [1:0] loop1_lock_window_o,
  output logic [1:0] loop2_lock_window_o,
  output logic loop2_ref_doubler_o,
  output logic loop2_fast_compare_enable_o,
  output logic powerdown_o,
  output logic [5:0] group_powerdown_o,
  output logic [5:0] group_source_select_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Two-bit code to prescale factor 1, 2, 4 or 8
  function automatic logic [3:0] prescale_factor(input logic [1:0] code);
    prescale_factor = 4'h1 << code;
  endfunction : prescale_factor

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] cfg_q [NUM_REGS];
  logic [31:0] shift_q;
  logic [31:0] rb_q;
  logic sclk_q;
  logic le_q;

  wire sclk_rise = serial_clock_i && !sclk_q;
  wire sclk_fall = !serial_clock_i && sclk_q;
  wire le_rise = serial_latch_enable_i && !le_q;
  wire [4:0] wr_addr = shift_q[ADDR_W-1:0];
  wire write_lock = cfg_q[REG_READBACK][POS_WLOCK];
  // The lock bit lives in register 31, which must stay writable or the
  // port could never be unlocked again
  wire write_ok = le_rise && (!write_lock || wr_addr == REG_READBACK);
  // A soft reset frame is consumed by the reload: register 0 keeps its
  // default, so the host need not write it again with the bit clear
  wire soft_reset = write_ok && wr_addr == 5'h00 &&
                    shift_q[POS_SOFT_RST];

  // ----------------------------------------------------------------
  // Serial port front end
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sclk_q <= 1'b0;
      le_q <= 1'b0;
    end else begin
      sclk_q <= serial_clock_i;
      le_q <= serial_latch_enable_i;
    end
  end

  // Frames arrive MSB first; the low five bits name the register.
  // The host must hold each serial clock level for at least one system clock,
  // otherwise an edge is missed and the frame slips by one bit
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      shift_q <= 32'h0000_0000;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[30:0], serial_data_i};
    end
  end

  // A latch to a locked register leaves storage untouched
  always_ff @(posedge clock_i) begin
    if (srst_i || soft_reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_q[i] <= reset_value(5'(i));
      end
    end else if (write_ok) begin
      cfg_q[wr_addr] <= {shift_q[31:5], 5'h00};
    end
  end

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  wire [31:0] trip_reg = cfg_q[REG_DAC_TRIP];
  wire [31:0] man_reg = cfg_q[REG_MANUAL_DAC];
  wire [5:0] high_trip = trip_reg[POS_HIGH_TRIP +: 6];
  wire [5:0] low_trip = trip_reg[POS_LOW_TRIP +: 6];
  wire rail_detect_en = trip_reg[POS_RAIL_DET];
  wire [9:0] manual_tuning_value = man_reg[POS_MANUAL_TUNING_VALUE +: 10];
  wire manual_tuning_override = man_reg[POS_MAN_EN];
  wire [13:0] hold_exit_count = man_reg[POS_COUNT +: 14];
  wire force_holdover = man_reg[POS_FORCE_HOLD];
  wire track_en = cfg_q[REG_HOLDOVER_MODE][POS_TRACK_EN];
  wire [1:0] hold_mode = cfg_q[REG_HOLDOVER_MODE][POS_HOLD_MODE +: 2];
  wire [9:0] dac_div = cfg_q[REG_DAC_CLK][POS_DAC_DIV +: 10];
  wire [13:0] loop1_count = cfg_q[REG_DAC_CLK][POS_COUNT +: 14];
  wire [13:0] loop2_count = cfg_q[REG_LOOP2_LOCK][POS_COUNT +: 14];
  wire rb_level = cfg_q[REG_READBACK][POS_RB_LEVEL];
  wire [4:0] rb_addr = cfg_q[REG_READBACK][POS_RB_ADDR +: 5];

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  // Divider and window fields are passed on raw; range checking is
  // left to the host, since an illegal code only mistunes the loop.
  // The loop-2 window resets to a reserved code and relies on the host
  // rewriting it during configuration
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      loop1_ref_divider_o <= 14'h0000;
      loop1_fb_divider_o <= 14'h0000;
      loop2_ref_divider_o <= 12'h000;
      loop2_fb_divider_o <= 18'h00000;
      loop2_prescaler_o <= 3'h0;
      ref_input_a_prescale_o <= 4'h1;
      ref_input_b_prescale_o <= 4'h1;
      loop1_lock_window_o <= 2'h0;
      loop2_lock_window_o <= 2'h0;
      loop2_ref_doubler_o <= 1'b0;
      loop2_fast_compare_enable_o <= 1'b0;
    end else begin
      loop1_ref_divider_o <= cfg_q[REG_LOOP1_REF][POS_DIV14 +: 14];
      loop1_fb_divider_o <= cfg_q[REG_LOOP2_REF][POS_DIV14 +: 14];
      loop2_ref_divider_o <= cfg_q[REG_LOOP2_REF][POS_L2_REF +: 12];
      loop2_fb_divider_o <= cfg_q[REG_LOOP2_FB][POS_DIV18 +: 18];
      loop2_prescaler_o <= cfg_q[REG_LOOP2_FB][POS_PRESCALER +: 3];
      ref_input_a_prescale_o <=
        prescale_factor(cfg_q[REG_LOOP1_REF][POS_PRE_A +: 2]);
      ref_input_b_prescale_o <=
        prescale_factor(cfg_q[REG_LOOP1_REF][POS_PRE_B +: 2]);
      loop1_lock_window_o <= cfg_q[REG_PATH_DELAY][POS_WND1 +: 2];
      loop2_lock_window_o <= cfg_q[REG_LOOP2_LOCK][POS_WND2 +: 2];
      loop2_ref_doubler_o <= cfg_q[REG_LOOP2_LOCK][POS_DOUBLER];
      loop2_fast_compare_enable_o <=
        cfg_q[REG_CAL_DIV][POS_FAST_PDF];
    end
  end

  // Register 1 carries the chip power-down, registers 0 to 5 their group power-down; only groups 3 and 4 may pick
  // the oscillator, the rest are tied to the VCO path
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      powerdown_o <= 1'b0;
      group_powerdown_o <= 6'h00;
      group_source_select_o <= 6'h00;
    end else begin
      powerdown_o <= cfg_q[5'h01][POS_POWERDOWN];
      for (int g = 0; g < 6; g++) begin
        group_powerdown_o[g] <= cfg_q[g][POS_GRP_PD];
        group_source_select_o[g] <= (g == 3 || g == 4) &&
                                    cfg_q[g][POS_GRP_SRC];
      end
    end
  end

  // ----------------------------------------------------------------
  // DAC update clock and value
  // ----------------------------------------------------------------
  logic [9:0] dac_cnt_q;
  logic [9:0] dac_q;
  wire dac_tick = pd1_tick_i && (dac_cnt_q + 10'h001 >= dac_div);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dac_cnt_q <= 10'h000;
      dac_update_o <= 1'b0;
    end else begin
      dac_update_o <= dac_tick;
      if (dac_tick) begin
        dac_cnt_q <= 10'h000;
      end else if (pd1_tick_i) begin
        dac_cnt_q <= dac_cnt_q + 10'h001;
      end
    end
  end

  // Without manual tuning override, holdover freezes the last tracked value so the oscillator stays put
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dac_q <= RST_MANUAL_DAC[POS_MANUAL_TUNING_VALUE +: 10];
    end else if (dac_tick) begin
      if (manual_tuning_override) begin
        dac_q <= manual_tuning_value;
      end else if (track_en && !holdover_o) begin
        dac_q <= track_dac_i;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dac_value_o <= RST_MANUAL_DAC[POS_MANUAL_TUNING_VALUE +: 10];
    end else begin
      dac_value_o <= dac_q;
    end
  end

  // Rail trips compare the live value against the guard bands.
  // With a zero low band a DAC value of zero still trips, which keeps a
  // stuck-low tuning rail from passing as locked
  wire trip_high = dac_q >= (DAC_FULL_SCALE - {4'h0, high_trip});
  wire trip_low = dac_q <= {4'h0, low_trip};
  wire rail_trip = rail_detect_en && (trip_high || trip_low);

  // ----------------------------------------------------------------
  // Lock detection and holdover
  // ----------------------------------------------------------------
  logic lock1_raw;
  logic lock2_raw;
  logic hold_exit_ok;
  logic lock1_prev_q;

  jcr_lock_counter u_loop1_lock (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .enable_i(1'b1),
    .tick_i(pd1_tick_i),
    .in_window_i(loop1_in_window_i),
    .target_i(loop1_count),
    .locked_o(lock1_raw)
  );

  jcr_lock_counter u_loop2_lock (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .enable_i(1'b1),
    .tick_i(pd2_tick_i),
    .in_window_i(loop2_in_window_i),
    .target_i(loop2_count),
    .locked_o(lock2_raw)
  );

  // Exit qualification only runs while holdover is active, so every
  // holdover episode must earn a fresh uninterrupted run of lock
  jcr_lock_counter u_hold_exit (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .enable_i(holdover_o),
    .tick_i(pd1_tick_i),
    .in_window_i(loop1_in_window_i && !rail_trip),
    .target_i(hold_exit_count),
    .locked_o(hold_exit_ok)
  );

  wire lock1_now = lock1_raw && !rail_trip;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      loop1_lock_o <= 1'b0;
      loop2_lock_o <= 1'b0;
      lock1_prev_q <= 1'b0;
    end else begin
      loop1_lock_o <= lock1_now;
      loop2_lock_o <= lock2_raw;
      lock1_prev_q <= lock1_now;
    end
  end

  wire lock_lost = lock1_prev_q && !lock1_now;
  wire hold_enter = force_holdover || rail_trip ||
                    (hold_mode == HOLD_MODE_ENABLE && lock_lost);

  // Entry wins over exit in the same cycle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      holdover_o <= 1'b0;
    end else if (hold_enter) begin
      holdover_o <= 1'b1;
    end else if (hold_exit_ok) begin
      holdover_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  // Manual tuning field reads back the live DAC value, not what was
  // written
  function automatic logic [31:0] read_word(input logic [4:0] a);
    read_word = cfg_q[a];
    if (a == REG_MANUAL_DAC) begin
      read_word[POS_MANUAL_TUNING_VALUE +: 10] = dac_q;
    end
  endfunction : read_word

  // Each latch snapshots the selected register for the next frame.
  // The address is taken from storage before the current frame lands,
  // so a new readback address takes effect one frame later
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rb_q <= 32'h0000_0000;
    end else if (le_rise) begin
      rb_q <= read_word(rb_addr);
    end else if (sclk_fall && serial_latch_enable_i == rb_level) begin
      rb_q <= {rb_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      readback_data_o <= 1'b0;
    end else begin
      readback_data_o <= (serial_latch_enable_i == rb_level) &&
                         rb_q[31];
    end
  end

endmodule : jcr_config_regs
`default_nettype wire

//--- tb/jcr_config_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module jcr_config_regs_properties
  import jcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic pd1_tick_i,
  input wire logic pd2_tick_i,
  input wire logic loop1_in_window_i,
  input wire logic loop2_in_window_i,
  input wire logic loop1_lock_o,
  input wire logic loop2_lock_o,
  input wire logic holdover_o,
  input wire logic dac_update_o,
  input wire logic [3:0] ref_input_a_prescale_o,
  input wire logic [3:0] ref_input_b_prescale_o,
  input wire logic [5:0] group_source_select_o
);
  // ----------
  // Tick history
  // ----------
  // Registered outputs lag their cause, so keep the last three ticks
  logic [2:0] win1_q;
  logic [2:0] win2_q;
  logic [2:0] tick1_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      win1_q <= 3'h0;
      win2_q <= 3'h0;
      tick1_q <= 3'h0;
    end else begin
      win1_q <= {win1_q[1:0], pd1_tick_i & loop1_in_window_i};
      win2_q <= {win2_q[1:0], pd2_tick_i & loop2_in_window_i};
      tick1_q <= {tick1_q[1:0], pd1_tick_i};
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  property p_prescale_legal;
    $onehot(ref_input_a_prescale_o) && $onehot(ref_input_b_prescale_o);
  endproperty
  a_prescale_legal: assert property (p_prescale_legal)
    else $error("prescale factor not 1, 2, 4 or 8");
  property p_group_src;
    group_source_select_o[2:0] == 3'h0 && !group_source_select_o[5];
  endproperty
  a_group_src: assert property (p_group_src)
    else $error("source select outside groups 3 and 4");
  property p_l1_drop;
    pd1_tick_i && !loop1_in_window_i |-> ##[1:3] !loop1_lock_o;
  endproperty
  a_l1_drop: assert property (p_l1_drop)
    else $error("loop-1 lock kept after out-of-window tick");
  property p_l2_drop;
    pd2_tick_i && !loop2_in_window_i |-> ##[1:3] !loop2_lock_o;
  endproperty
  a_l2_drop: assert property (p_l2_drop)
    else $error("loop-2 lock kept after out-of-window tick");
  property p_l1_rise;
    $rose(loop1_lock_o) |-> |win1_q;
  endproperty
  a_l1_rise: assert property (p_l1_rise)
    else $error("loop-1 lock rose without in-window tick");
  property p_l2_rise;
    $rose(loop2_lock_o) |-> |win2_q;
  endproperty
  a_l2_rise: assert property (p_l2_rise)
    else $error("loop-2 lock rose without in-window tick");
  property p_hold_on_loss;
    $fell(loop1_lock_o) |-> ##[0:3] holdover_o;
  endproperty
  a_hold_on_loss: assert property (p_hold_on_loss)
    else $error("no holdover after loss of loop-1 lock");
  property p_dac_tick;
    dac_update_o |-> |tick1_q;
  endproperty
  a_dac_tick: assert property (p_dac_tick)
    else $error("DAC update without loop-1 tick");
endmodule : jcr_config_regs_properties

bind jcr_config_regs jcr_config_regs_properties jcr_config_regs_properties_i (
  .*
);
`default_nettype wire

//--- tb/jcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module jcr_host_model
  import jcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic readback_data_i,
  output logic serial_clock_o,
  output logic serial_data_o,
  output logic serial_latch_enable_o
);
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
    serial_latch_enable_o = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc

  // ----------
  // Frames
  // ----------
  // Serial clock rests low between frames; each level lasts two clocks
  task automatic send_frame(input logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      serial_data_o = f[i];
      cyc(2);
      serial_clock_o = 1'b1;
      cyc(2);
      serial_clock_o = 1'b0;
    end
    serial_data_o = ~f[0];
    serial_latch_enable_o = 1'b1;
    cyc(3);
    serial_latch_enable_o = 1'b0;
    cyc(4);
  endtask : send_frame

  task automatic write_reg(input logic [4:0] a, input logic [31:0] d);
    send_frame({d[31:5], a});
  endtask : write_reg

  // Second latch snapshots with the new address already in place
  task automatic read_reg(input logic [4:0] a, output logic [31:0] v);
    repeat (2) send_frame({11'h0, a, 11'h0, 5'h1F});
    for (int i = 31; i >= 0; i--) begin
      cyc(3);
      v[i] = readback_data_i;
      serial_data_o = ~serial_data_o;
      serial_clock_o = 1'b1;
      cyc(2);
      serial_clock_o = 1'b0;
    end
  endtask : read_reg
endmodule : jcr_host_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import jcr_pkg::*;
;
  logic clock_i, srst_i, pd1_tick_i, pd2_tick_i;
  logic loop1_in_window_i, loop2_in_window_i;
  logic serial_clock_i, serial_data_i, serial_latch_enable_i;
  logic readback_data_o, loop1_lock_o, loop2_lock_o, holdover_o;
  logic dac_update_o, loop2_ref_doubler_o, loop2_fast_compare_enable_o;
  logic powerdown_o;
  logic [9:0] track_dac_i, dac_value_o;
  logic [13:0] loop1_ref_divider_o, loop1_fb_divider_o;
  logic [11:0] loop2_ref_divider_o;
  logic [17:0] loop2_fb_divider_o;
  logic [2:0] loop2_prescaler_o;
  logic [3:0] ref_input_a_prescale_o, ref_input_b_prescale_o;
  logic [1:0] loop1_lock_window_o, loop2_lock_window_o;
  logic [5:0] group_powerdown_o, group_source_select_o;
  logic [31:0] rd;
  int fails = 0;
  int checked = 0;
  int upd_cnt = 0;
  int le_cnt = 0;
  int n;

  jcr_config_regs jcr_config_regs_i (.*);
  jcr_host_model jcr_host_model_i (.clock_i(clock_i),
    .readback_data_i(readback_data_o), .serial_clock_o(serial_clock_i),
    .serial_data_o(serial_data_i),
    .serial_latch_enable_o(serial_latch_enable_i));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic finish_test;
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ----------
  // Monitors
  // ----------
  always @(posedge clock_i) begin
    if (dac_update_o === 1'b1) upd_cnt++;
    le_cnt = (serial_latch_enable_i === 1'b1) ? le_cnt + 1 : 0;
    if (le_cnt == 2) chk(readback_data_o, 1'b0, "rb with latch high");
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    jcr_host_model_i.write_reg(a, d);
  endtask : wr

  task automatic tick(input bit two, input logic win, input int k);
    repeat (k) begin
      loop1_in_window_i = win;
      loop2_in_window_i = win;
      if (two) pd2_tick_i = 1'b1;
      else pd1_tick_i = 1'b1;
      cyc(1);
      pd1_tick_i = 1'b0;
      pd2_tick_i = 1'b0;
      cyc(3);
    end
  endtask : tick

  // ----------
  // Scenarios
  // ----------
  task automatic sc_defaults;
    chk(loop1_ref_divider_o, 14'h60, "l1 ref");
    chk(loop1_fb_divider_o, 14'hC0, "l1 fb");
    chk(loop2_ref_divider_o, 12'h4, "l2 ref");
    chk({loop2_fb_divider_o, loop2_prescaler_o}, {18'h30, 3'h2}, "l2 fb");
    chk(ref_input_a_prescale_o | ref_input_b_prescale_o, 4'h1, "pre");
    chk(loop1_lock_window_o, 2'h3, "l1 window");
    chk({loop2_fast_compare_enable_o, loop2_ref_doubler_o}, 2'h2, "l2");
    chk(dac_value_o, 10'h200, "dac");
  endtask : sc_defaults

  task automatic sc_dac_rate;
    wr(REG_DAC_CLK, {10'h2, 2'h0, 14'h5, 6'h0});
    tick(0, 0, 2);
    upd_cnt = 0;
    tick(0, 0, 8);
    chk(upd_cnt, 32'h4, "dac updates");
    chk(dac_value_o, 10'h0AB, "tracking");
  endtask : sc_dac_rate

  task automatic sc_lock1;
    tick(0, 1, 4);
    tick(0, 0, 1);
    tick(0, 1, 4);
    chk(loop1_lock_o, 1'b0, "early lock");
    tick(0, 1, 1);
    chk(loop1_lock_o, 1'b1, "lock");
    tick(0, 0, 1);
    chk({loop1_lock_o, holdover_o}, 2'h1, "hold on loss");
    wr(REG_MANUAL_DAC, {12'h0, 14'h3, 6'h0});
    tick(0, 1, 2);
    chk(holdover_o, 1'b1, "early exit");
    n = 0;
    while (holdover_o !== 1'b0 && n < 12) begin
      tick(0, 1, 1);
      n++;
    end
    chk(holdover_o, 1'b0, "exit");
    if (n == 12) finish_test;
  endtask : sc_lock1

  task automatic sc_rail;
    wr(REG_DAC_TRIP, {12'h0, 6'h10, 2'h0, 6'h0, 1'b1, 5'h0});
    track_dac_i = 10'h3EE;
    tick(0, 1, 4);
    chk({loop1_lock_o, holdover_o}, 2'h2, "below trip");
    track_dac_i = 10'h3EF;
    tick(0, 1, 4);
    chk({loop1_lock_o, holdover_o}, 2'h1, "rail trip");
    // Break the lock run first so clearing the trip raises no lock edge
    tick(0, 0, 1);
    wr(REG_DAC_TRIP, 32'h0);
  endtask : sc_rail

  task automatic sc_manual;
    wr(REG_MANUAL_DAC, {10'h155, 2'h1, 14'h3, 6'h0});
    tick(0, 0, 4);
    chk(dac_value_o, 10'h155, "manual");
    jcr_host_model_i.read_reg(REG_MANUAL_DAC, rd);
    chk(rd[31:22], 10'h155, "dac readback");
  endtask : sc_manual

  task automatic sc_config;
    for (int c = 0; c < 4; c++) begin
      wr(REG_LOOP1_REF, {8'h0, c[1:0], ~c[1:0], 14'h3FFF, 6'h0});
      chk(ref_input_b_prescale_o, 4'h1 << c, "pre b");
      chk(ref_input_a_prescale_o, 4'h1 << (3 - c), "pre a");
    end
    chk(loop1_ref_divider_o, 14'h3FFF, "l1 ref max");
    wr(REG_LOOP2_REF, {12'hFFF, 14'h1, 6'h0});
    wr(REG_CAL_DIV, {9'h0, 18'h3FFFF, 5'h0});
    wr(REG_LOOP2_FB, {5'h0, 3'h5, 1'b0, 18'h3FFFF, 5'h0});
    wr(REG_LOOP2_LOCK, {2'h2, 1'b1, 9'h0, 14'h3, 6'h0});
    wr(REG_PATH_DELAY, {24'h0, 2'h1, 6'h0});
    chk({loop2_ref_divider_o, loop1_fb_divider_o}, 26'h3FFC001, "div");
    chk({loop2_fb_divider_o, loop2_prescaler_o}, 21'h1FFFFD, "l2 fb");
    chk(loop2_fast_compare_enable_o, 1'b0, "fast");
    chk({loop2_lock_window_o, loop2_ref_doubler_o}, 3'h5, "dbl");
    chk(loop1_lock_window_o, 2'h1, "l1 window");
    tick(1, 1, 2);
    chk(loop2_lock_o, 1'b0, "l2 early");
    tick(1, 1, 1);
    chk(loop2_lock_o, 1'b1, "l2 lock");
    tick(1, 0, 1);
    chk(loop2_lock_o, 1'b0, "l2 drop");
  endtask : sc_config

  task automatic sc_readback;
    jcr_host_model_i.read_reg(REG_LOOP2_REF, rd);
    chk(rd, {12'hFFF, 14'h1, 6'h0}, "readback");
  endtask : sc_readback

  task automatic sc_wlock;
    wr(REG_READBACK, {26'h0, 1'b1, 5'h0});
    wr(REG_LOOP2_REF, {12'h7, 20'h0});
    chk(loop2_ref_divider_o, 12'hFFF, "locked write");
    wr(REG_READBACK, 32'h0);
    wr(REG_LOOP2_REF, {12'h7, 20'h0});
    chk(loop2_ref_divider_o, 12'h7, "unlocked");
  endtask : sc_wlock

  task automatic sc_groups;
    for (int g = 0; g < 6; g++) wr(g[4:0], {2'h3, 12'h0, (g > 1), 17'h0});
    chk({group_powerdown_o, group_source_select_o, powerdown_o},
        {6'h3F, 6'h18, 1'b0}, "groups");
    wr(5'h1, {14'h0, 1'b1, 17'h0});
    chk({group_powerdown_o[1], powerdown_o}, 2'h1, "power-down");
    wr(5'h0, {14'h0, 1'b1, 17'h0});
    chk({loop2_ref_divider_o, group_powerdown_o}, 18'h100, "soft rst");
  endtask : sc_groups

  initial begin
    srst_i = 1'b1;
    pd1_tick_i = 1'b0;
    pd2_tick_i = 1'b0;
    loop1_in_window_i = 1'b0;
    loop2_in_window_i = 1'b0;
    track_dac_i = 10'h0AB;
    cyc(12);
    srst_i = 1'b0;
    cyc(3);
    sc_defaults;
    sc_dac_rate;
    sc_lock1;
    sc_rail;
    sc_manual;
    sc_config;
    sc_readback;
    sc_wlock;
    sc_groups;
    finish_test;
  end

  initial begin
    #500000;
    fails++;
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
